// file: logic/uart_status_pkg.sv
`default_nettype none
package uart_status_pkg;
  // Byte offsets of the APB register map
  localparam logic [7:0] LINE_STATUS_ADDR  = 8'h00;
  localparam logic [7:0] MODEM_STATUS_ADDR = 8'h04;
  localparam logic [7:0] MODEM_CTRL_ADDR   = 8'h08;
  localparam logic [7:0] CONFIG_ADDR       = 8'h0C;
  localparam logic [7:0] EVENT_STAT_ADDR   = 8'h10;
  localparam logic [7:0] EVENT_MASK_ADDR   = 8'h14;
  localparam logic [7:0] RX_DATA_ADDR      = 8'h18;
  // Line status fields
  localparam int LS_READY   = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY  = 2;
  // Modem status fields
  localparam int MS_DCTS = 0;
  localparam int MS_DDSR = 1;
  localparam int MS_TERI = 2;
  localparam int MS_DDCD = 3;
  localparam int MS_CTS  = 4;
  localparam int MS_DSR  = 5;
  localparam int MS_RI   = 6;
  localparam int MS_DCD  = 7;
  // Modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  // Config fields
  localparam int CF_FIFO_EN = 0;
  localparam int CF_PAR_EN  = 1;
  localparam int CF_PAR_EVN = 2;
  // Event status fields
  localparam int EV_MODEM   = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_PARITY  = 2;
  localparam int EV_WIDTH   = 3;
  // Reset values
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [2:0] CONFIG_RST     = 3'h0;
  localparam logic [2:0] EVENT_MASK_RST = 3'h0;
  localparam int FIFO_DEPTH_DEF = 32;
endpackage : uart_status_pkg
`default_nettype wire

// file: logic/rx_status_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// Receive queue of characters with their parity error bit
module rx_status_fifo
  import uart_status_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic       sys_clk,   // Clock
  input  wire logic       rstn,      // Async reset, low
  input  wire logic [7:0] wr_data,   // Character in
  input  wire logic       wr_perr,   // Parity error of character in
  input  wire logic       wr_en,     // Push
  input  wire logic       rd_en,     // Pop head
  output logic      [7:0] head_data, // Head character
  output logic            head_perr, // Head parity error
  output logic            empty,     // Nothing held
  output logic            full       // Depth reached
);
  localparam int AW = $clog2(DEPTH);
  logic [8:0]  mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0]   count;
  logic          do_wr;
  logic          do_rd;

  assign do_wr     = wr_en && !full;
  assign do_rd     = rd_en && !empty;
  assign empty     = (count == '0);
  assign full      = (count == (AW+1)'(DEPTH));
  assign head_data = mem[rd_ptr][7:0];
  assign head_perr = !empty && mem[rd_ptr][8];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= {wr_perr, wr_data};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : rx_status_fifo
`default_nettype wire

// file: logic/uart_line_modem_status.sv
// Function
// - parity mismatch sets line status bit 2
// - FIFO mode: parity flag follows FIFO head
// - char completed while FIFO full sets overrun
// - overrun char replaces shift register, not queued
// - bit 0 set while any character held
// - line status flags zero after reset
// - four change bits set on input change
// - modem status read clears change bits
// - bit 7 carrier detect or user output two
// - bit 6 ring indicator or user output one
// - bit 5 set ready or terminal ready
// - bit 4 clear-to-send or request-to-send
// - ring change bit only on rising input
// - any change bit requests modem interrupt
// - change bits zero after reset
`timescale 1ns/1ns
`default_nettype none
module uart_line_modem_status
  import uart_status_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic        sys_clk,              // 20 MHz clock
  input  wire logic        rstn,                 // Async reset, low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB direction
  input  wire logic [7:0]  paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire logic [7:0]  rx_char,              // Received character
  input  wire logic        rx_char_parity,       // Parity bit received
  input  wire logic        rx_char_valid,        // Character complete pulse
  input  wire logic        cts_n,                // Clear-to-send pin, low
  input  wire logic        dsr_n,                // Data set ready pin, low
  input  wire logic        ring_indicator_in_n,  // Ring indicator pin, low
  input  wire logic        carrier_detect_in_n,  // Carrier detect pin, low
  output logic             dtr_n,                // Terminal ready pin, low
  output logic             rts_n,                // Request-to-send pin, low
  output logic             user_output_one_n,    // First user output, low
  output logic             user_output_two_n,    // Second user output, low
  output logic             modem_irq,            // Modem status request
  output logic             irq                   // Masked event interrupt
);
  logic [7:0] modem_control;
  logic [2:0] config_reg;
  logic [2:0] event_stat;
  logic [2:0] event_mask;
  logic [3:0] delta;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] pin_prev;
  logic       overrun;
  logic [7:0] shift_char;
  logic       shift_perr;
  logic       hold_valid;
  logic       hold_perr;
  logic [7:0] hold_char;
  logic [3:0] modem_level;
  logic [3:0] pin_now;
  logic [3:0] pin_change;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic       rd_access;
  logic       wr_access;
  logic       rd_line;
  logic       rd_modem;
  logic       rd_data;
  logic       char_perr;
  logic       fifo_mode;
  logic       fifo_full;
  logic       fifo_empty;
  logic       fifo_perr;
  logic [7:0] fifo_char;
  logic       q_full;
  logic       accept;
  logic       next_irq;
  logic       rd_event;
  logic       line_ready;
  logic       line_perr;
  logic [2:0] event_set;
  logic [3:0] loop_level;

  // Address decode used by the error answer only; the read mux has its own case
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      LINE_STATUS_ADDR, MODEM_STATUS_ADDR, MODEM_CTRL_ADDR, CONFIG_ADDR,
      EVENT_STAT_ADDR, EVENT_MASK_ADDR, RX_DATA_ADDR: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // High when the character and its parity bit break the chosen parity
  function automatic logic parity_bad(input logic [7:0] ch, input logic pb,
                                      input logic even);
    parity_bad = ((^{ch, pb}) == even);
  endfunction : parity_bad

  assign rd_access = psel && penable && !pwrite && !pready;
  assign wr_access = psel && penable && pwrite && !pready;
  assign rd_line   = rd_access && (paddr == LINE_STATUS_ADDR);
  assign rd_modem  = rd_access && (paddr == MODEM_STATUS_ADDR);
  assign rd_data   = rd_access && (paddr == RX_DATA_ADDR);
  assign rd_event  = rd_access && (paddr == EVENT_STAT_ADDR);
  assign fifo_mode = config_reg[CF_FIFO_EN];

  // Parity check, only while parity is enabled
  assign char_perr = config_reg[CF_PAR_EN] &&
                     parity_bad(rx_char, rx_char_parity, config_reg[CF_PAR_EVN]);

  // A character meeting a full queue is an overrun
  assign q_full = fifo_mode ? fifo_full : hold_valid;
  assign accept = rx_char_valid && !q_full;

  rx_status_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_data   (rx_char),
    .wr_perr   (char_perr),
    .wr_en     (accept && fifo_mode),
    .rd_en     (rd_data && fifo_mode),
    .head_data (fifo_char),
    .head_perr (fifo_perr),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // Holding register for non-FIFO mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_valid <= 1'b0;
      hold_perr  <= 1'b0;
      hold_char  <= 8'h00;
    end else if (accept && !fifo_mode) begin
      hold_valid <= 1'b1;
      hold_perr  <= char_perr;
      hold_char  <= rx_char;
    end else if (rd_data || fifo_mode) begin
      hold_valid <= 1'b0;
    end
  end

  // Shift register copy; overrun replaces it without queueing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_char <= 8'h00;
      shift_perr <= 1'b0;
    end else if (rx_char_valid) begin
      shift_char <= rx_char;
      shift_perr <= char_perr;
    end
  end

  // Overrun flag, cleared by line status read; set wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      overrun <= 1'b0;
    end else if (rx_char_valid && q_full) begin
      overrun <= 1'b1;
    end else if (rd_line) begin
      overrun <= 1'b0;
    end
  end

  // Head of queue in FIFO mode, holding register otherwise
  assign line_perr   = fifo_mode ? fifo_perr : (hold_valid && hold_perr);
  assign line_ready  = fifo_mode ? !fifo_empty : hold_valid;
  assign line_status = {5'h00, line_perr, overrun, line_ready};

  // Two-stage synchronisers: cts, dsr, ring, carrier
  // Reset to the idle high level so release shows no edge
  assign pin_now = {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1    <= 4'hF;
      sync2    <= 4'hF;
      pin_prev <= 4'hF;
    end else begin
      sync1    <= pin_now;
      sync2    <= sync1;
      pin_prev <= sync2;
    end
  end

  // Loop-back feeds modem control bits in place of the pins
  assign loop_level  = {modem_control[MC_OUT2], modem_control[MC_OUT1],
                        modem_control[MC_DTR], modem_control[MC_RTS]};
  assign modem_level = modem_control[MC_LOOP] ? loop_level : ~sync2;

  // Ring counts only its release; the others count any edge
  for (genvar g = 0; g < 4; g++) begin : g_edge
    if (g == MS_TERI) begin : g_rise
      assign pin_change[g] = sync2[g] && !pin_prev[g];
    end else begin : g_any
      assign pin_change[g] = sync2[g] ^ pin_prev[g];
    end
  end

  // Change bits: set beats the clearing read
  // Deltas come from the pins only, never from loop-back levels
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      delta <= 4'h0;
    end else begin
      delta <= (rd_modem ? 4'h0 : delta) | pin_change;
    end
  end

  assign modem_status = {modem_level[3], modem_level[2], modem_level[1], modem_level[0],
                         delta};

  assign event_set = {rx_char_valid && char_perr, rx_char_valid && q_full, |pin_change};

  // Sticky event bits, cleared by a read of the event register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      event_stat <= 3'h0;
    end else begin
      event_stat <= (rd_event ? 3'h0 : event_stat) | event_set;
    end
  end

  // Software writable registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modem_control <= MODEM_CTRL_RST;
      config_reg    <= CONFIG_RST;
      event_mask    <= EVENT_MASK_RST;
    end else if (wr_access) begin
      case (paddr)
        MODEM_CTRL_ADDR: modem_control <= {3'h0, pwdata[4:0]};
        CONFIG_ADDR:     config_reg    <= pwdata[2:0];
        EVENT_MASK_ADDR: event_mask    <= pwdata[2:0];
        default:         modem_control <= modem_control;
      endcase
    end
  end

  // APB answer: one wait state, every output registered
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          LINE_STATUS_ADDR:  prdata <= {24'h0, line_status};
          MODEM_STATUS_ADDR: prdata <= {24'h0, modem_status};
          MODEM_CTRL_ADDR:   prdata <= {24'h0, modem_control};
          CONFIG_ADDR:       prdata <= {29'h0, config_reg};
          EVENT_STAT_ADDR:   prdata <= {29'h0, event_stat};
          EVENT_MASK_ADDR:   prdata <= {29'h0, event_mask};
          RX_DATA_ADDR:      prdata <= {24'h0, fifo_mode ? fifo_char : hold_char};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign next_irq = |(event_stat & event_mask);

  // Outputs from flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modem_irq         <= 1'b0;
      irq               <= 1'b0;
      dtr_n             <= 1'b1;
      rts_n             <= 1'b1;
      user_output_one_n <= 1'b1;
      user_output_two_n <= 1'b1;
    end else begin
      modem_irq         <= |delta;
      irq               <= next_irq;
      dtr_n             <= !modem_control[MC_DTR] || modem_control[MC_LOOP];
      rts_n             <= !modem_control[MC_RTS] || modem_control[MC_LOOP];
      user_output_one_n <= !modem_control[MC_OUT1] || modem_control[MC_LOOP];
      user_output_two_n <= !modem_control[MC_OUT2] || modem_control[MC_LOOP];
    end
  end
endmodule : uart_line_modem_status
`default_nettype wire

// file: tb/uart_lms_checker.sv
`timescale 1ns/1ns
`default_nettype none
module uart_lms_checker
  import uart_status_pkg::*;
(
  input wire logic        sys_clk,             // Clock
  input wire logic        rstn,                // Reset, low
  input wire logic        psel,                // Select
  input wire logic        penable,             // Enable
  input wire logic        pwrite,              // Direction
  input wire logic [7:0]  paddr,               // Address
  input wire logic [31:0] prdata,              // Read data
  input wire logic        pready,              // Ready
  input wire logic        pslverr,             // Error
  input wire logic        cts_n,               // Pin
  input wire logic        dsr_n,               // Pin
  input wire logic        ring_indicator_in_n, // Pin
  input wire logic        carrier_detect_in_n, // Pin
  input wire logic        dtr_n,               // Output
  input wire logic        rts_n,               // Output
  input wire logic        user_output_one_n,   // Output
  input wire logic        user_output_two_n,   // Output
  input wire logic        modem_irq            // Modem request
);
  wire logic [3:0] pins = {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n};
  wire logic       ms_rd = pready & !pwrite & (paddr == MODEM_STATUS_ADDR);
  wire logic       outs_hi = &{dtr_n, rts_n, user_output_one_n, user_output_two_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  pready_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  slverr_only_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_a: assert property (pready && paddr > RX_DATA_ADDR |-> pslverr)
    else $error("unmapped access not flagged");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  slverr_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  irq_on_a: assert property (ms_rd && prdata[3:0] != 4'h0 |-> modem_irq)
    else $error("modem request missing");
  irq_drop_a: assert property ($stable(pins) [*6] ##0 ms_rd |=> !modem_irq)
    else $error("modem request stuck");
  modem_level_a: assert property ($stable(pins) [*4] ##0 (ms_rd && !outs_hi) |->
    prdata[7:4] == ~pins) else $error("modem level wrong");
endmodule : uart_lms_checker
bind uart_line_modem_status uart_lms_checker chk_i (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
  .dsr_n(dsr_n), .ring_indicator_in_n(ring_indicator_in_n),
  .carrier_detect_in_n(carrier_detect_in_n), .dtr_n(dtr_n), .rts_n(rts_n),
  .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
  .modem_irq(modem_irq));
`default_nettype wire

// file: tb/modem_pins.sv
`timescale 1ns/1ns
`default_nettype none
module modem_pins (
  input  wire logic       sys_clk,             // Clock
  input  wire logic [3:0] want,                // Levels asked, {cd, ri, dsr, cts}
  input  wire logic [1:0] lag,                 // Response delay in cycles
  output logic            cts_n,               // Clear-to-send
  output logic            dsr_n,               // Data set ready
  output logic            ring_indicator_in_n, // Ring indicator
  output logic            carrier_detect_in_n  // Carrier detect
);
  logic [3:0] cur = 4'hF;
  logic [1:0] cnt = 2'h0;
  // Slow modem: follows a request only after lag cycles
  always @(posedge sys_clk) begin
    if (want == cur) begin
      cnt <= 2'h0;
    end else if (cnt >= lag) begin
      cur <= want;
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  assign {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n} = cur;
endmodule : modem_pins
`default_nettype wire

// file: tb/test_uart_line_modem_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_uart_line_modem_status;
  import uart_status_pkg::*;
  localparam int DEPTH = 4;
  logic        sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rx_char = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, rx_char_parity = 1'b0, rx_char_valid = 1'b0;
  logic        cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, uo1_n, uo2_n, modem_irq, irq;
  logic [3:0]  want = 4'hF;
  logic [1:0]  lag = 2'h0;
  logic [8:0]  exp_q[$], msk_q[$];
  logic [7:0]  fifo_q[$];
  int          miscompares = 0, n_compared = 0, cycles = 0, seed = 32'hbe42, i;
  uart_line_modem_status #(.FIFO_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char(rx_char),
    .rx_char_parity(rx_char_parity), .rx_char_valid(rx_char_valid), .cts_n(cts_n),
    .dsr_n(dsr_n), .ring_indicator_in_n(ri_n), .carrier_detect_in_n(cd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(uo1_n), .user_output_two_n(uo2_n),
    .modem_irq(modem_irq), .irq(irq));
  modem_pins mdm (.sys_clk(sys_clk), .want(want), .lag(lag), .cts_n(cts_n),
    .dsr_n(dsr_n), .ring_indicator_in_n(ri_n), .carrier_detect_in_n(cd_n));
  always #25 sys_clk = ~sys_clk;
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end
  // Answer monitor: oldest note against {pslverr, prdata[7:0]}
  always @(posedge sys_clk) if (pready === 1'b1) begin
    n_compared++;
    if (({pslverr, prdata[7:0]} & msk_q[0]) !== exp_q[0]) begin
      $display("mismatch apb %h exp %h seen %h", paddr, exp_q[0], {pslverr, prdata[7:0]});
      miscompares++;
    end
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic [8:0] e, input logic [8:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(a, 1'b0, 8'h00, {1'b0, e}, {1'b1, m});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 9'h000, 9'h100);
  endtask : wr
  task automatic rx(input logic [7:0] ch, input logic bad);
    @(posedge sys_clk);
    rx_char <= ch;
    rx_char_parity <= ^ch ^ bad;
    rx_char_valid <= 1'b1;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
  endtask : rx
  task automatic pin(input int k, input logic v);
    want[k] <= v;
    repeat (12) @(posedge sys_clk);
  endtask : pin
  task automatic chk(input string n, input logic got, input logic ex);
    n_compared++;
    if (got !== ex) begin
      $display("mismatch %s exp %b seen %b", n, ex, got);
      miscompares++;
    end
  endtask : chk
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(LINE_STATUS_ADDR, 8'h00, 8'h07);
    rd(MODEM_STATUS_ADDR, 8'h00, 8'hFF);
    apb(8'h1C, 1'b0, 8'h00, 9'h100, 9'h1FF);
    apb(8'h1C, 1'b1, 8'hFF, 9'h100, 9'h100);
    wr(CONFIG_ADDR, 8'h06);
    rx(8'h5A, 1'b0);
    rd(LINE_STATUS_ADDR, 8'h01, 8'h07);
    rx(8'hA7, 1'b0);
    rd(LINE_STATUS_ADDR, 8'h03, 8'h07);
    rd(LINE_STATUS_ADDR, 8'h01, 8'h07);
    rd(RX_DATA_ADDR, 8'h5A, 8'hFF);
    rd(LINE_STATUS_ADDR, 8'h00, 8'h07);
    wr(CONFIG_ADDR, 8'h07);
    rx(8'h31, 1'b0);
    rx(8'h32, 1'b1);
    rd(LINE_STATUS_ADDR, 8'h01, 8'h07);
    rd(RX_DATA_ADDR, 8'h31, 8'hFF);
    rd(LINE_STATUS_ADDR, 8'h05, 8'h07);
    rd(RX_DATA_ADDR, 8'h32, 8'hFF);
    for (i = 0; i < DEPTH; i++) begin
      c = 8'($random(seed));
      fifo_q.push_back(c);
      rx(c, 1'b0);
    end
    rx(8'hEE, 1'b0);
    rd(LINE_STATUS_ADDR, 8'h03, 8'h07);
    for (i = 0; i < DEPTH; i++) rd(RX_DATA_ADDR, fifo_q[i], 8'hFF);
    rd(LINE_STATUS_ADDR, 8'h00, 8'h07);
    wr(MODEM_CTRL_ADDR, 8'h0F);
    @(negedge sys_clk);
    chk("dtr_n", dtr_n, 1'b0);
    chk("rts_n", rts_n, 1'b0);
    chk("uo1_n", uo1_n, 1'b0);
    chk("uo2_n", uo2_n, 1'b0);
    wr(EVENT_MASK_ADDR, 8'h01);
    for (i = 0; i < 4; i++) begin
      lag <= 2'($random(seed));
      pin(i, 1'b0);
      rd(MODEM_STATUS_ADDR, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i), 8'hFF);
      rd(MODEM_STATUS_ADDR, 8'h10 << i, 8'hFF);
      pin(i, 1'b1);
      rd(MODEM_STATUS_ADDR, 8'h01 << i, 8'hFF);
    end
    @(negedge sys_clk);
    chk("irq", irq, 1'b1);
    rd(EVENT_STAT_ADDR, 8'h07, 8'h07);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", irq, 1'b0);
    wr(EVENT_MASK_ADDR, 8'h00);
    pin(0, 1'b0);
    @(negedge sys_clk);
    chk("irq", irq, 1'b0);
    chk("modem_irq", modem_irq, 1'b1);
    rd(EVENT_STAT_ADDR, 8'h01, 8'h07);
    rd(MODEM_STATUS_ADDR, 8'h11, 8'hFF);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("modem_irq", modem_irq, 1'b0);
    for (i = 0; i < 16; i++) begin
      wr(MODEM_CTRL_ADDR, 8'h10 | i[7:0]);
      rd(MODEM_STATUS_ADDR, {i[3], i[2], i[0], i[1], 4'h0}, 8'hFF);
    end
    @(negedge sys_clk);
    chk("dtr_n", dtr_n, 1'b1);
    chk("uo2_n", uo2_n, 1'b1);
    give_verdict;
  end
endmodule : test_uart_line_modem_status
`default_nettype wire
